// File: arcc_map.vh
// register offsets, field positions and reset values of the converter register block
`ifndef ARCC_MAP_VH
`define ARCC_MAP_VH

`define ARCC_ADDR_W 8
`define ARCC_OFF_RESULT_HIGH 8'h00
`define ARCC_OFF_RESULT_LOW 8'h04
`define ARCC_OFF_CMP_HIGH 8'h08
`define ARCC_OFF_CMP_LOW 8'h0c
`define ARCC_OFF_CONFIG 8'h10
`define ARCC_OFF_PIN_DIS_0_7 8'h14
`define ARCC_OFF_PIN_DIS_8_15 8'h18

`define ARCC_CFG_LOW_POWER 7
`define ARCC_CFG_DIV_HI 6
`define ARCC_CFG_DIV_LO 5
`define ARCC_CFG_LONG_SAMPLE 4
`define ARCC_CFG_MODE_HI 3
`define ARCC_CFG_MODE_LO 2
`define ARCC_CFG_SRC_HI 1
`define ARCC_CFG_SRC_LO 0

`define ARCC_MODE_8BIT 2'b00
`define ARCC_MODE_10BIT 2'b10

`define ARCC_SRC_BUS 2'b00
`define ARCC_SRC_BUS_HALF 2'b01
`define ARCC_SRC_ALT 2'b10
`define ARCC_SRC_ASYNC 2'b11

`define ARCC_RST_CONFIG 8'h00
`define ARCC_RST_CMP 8'h00
`define ARCC_RST_PIN_DIS 8'h00
`define ARCC_RST_RESULT 8'h00

`endif

// File: arcc_clk_gen.v
// converter clock tick generator: source select, divide, glitch-free change
`timescale 1ns/1ps
`default_nettype none

`include "arcc_map.vh"

module arcc_clk_gen (
    input wire clk_i,
    input wire rst_i,
    input wire [1:0] src_sel_i,
    input wire [1:0] div_sel_i,
    input wire alternate_clock_i,
    input wire internal_async_clock_i,
    input wire hold_i,
    output wire converter_clock_o
);
    reg [1:0] src_q;
    reg [1:0] div_q;
    reg half_q;
    reg alt_prev_q;
    reg async_prev_q;
    reg [2:0] cnt_q;
    reg tick_q;
    reg src_tick;
    reg [2:0] limit;

    always @* begin
        case (src_q)
            `ARCC_SRC_BUS: src_tick = 1'b1;
            `ARCC_SRC_BUS_HALF: src_tick = half_q;
            `ARCC_SRC_ALT: src_tick = alternate_clock_i & ~alt_prev_q;
            default: src_tick = internal_async_clock_i & ~async_prev_q;
        endcase
        case (div_q)
            2'b00: limit = 3'h0;
            2'b01: limit = 3'h1;
            2'b10: limit = 3'h3;
            default: limit = 3'h7;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            src_q <= `ARCC_SRC_BUS;
            div_q <= 2'b00;
            half_q <= 1'b0;
            alt_prev_q <= 1'b0;
            async_prev_q <= 1'b0;
            cnt_q <= 3'h0;
            tick_q <= 1'b0;
        end else begin
            half_q <= ~half_q;
            alt_prev_q <= alternate_clock_i;
            async_prev_q <= internal_async_clock_i;
            // new setting only between conversions and on a period boundary;
            // a pending pulse must not block this, divide-by-1 from the bus clock pulses every cycle
            if (!hold_i && (cnt_q == 3'h0) &&
                ((src_q != src_sel_i) || (div_q != div_sel_i))) begin
                src_q <= src_sel_i;
                div_q <= div_sel_i;
                tick_q <= 1'b0;
            end else if (src_tick) begin
                if (cnt_q >= limit) begin
                    cnt_q <= 3'h0;
                    tick_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 3'h1;
                    tick_q <= 1'b0;
                end
            end else begin
                tick_q <= 1'b0;
            end
        end
    end

    assign converter_clock_o = tick_q;
endmodule

`default_nettype wire

// File: arcc_pin_gate.v
// analog pin gating of port output, input and pullup, registered
`timescale 1ns/1ps
`default_nettype none

module arcc_pin_gate #(
    parameter WIDTH = 8
) (
    input wire clk_i,
    input wire rst_i,
    input wire [WIDTH-1:0] disable_i,
    input wire [WIDTH-1:0] port_oe_i,
    input wire [WIDTH-1:0] port_pullup_i,
    input wire [WIDTH-1:0] pad_in_i,
    output reg [WIDTH-1:0] pad_oe_o,
    output reg [WIDTH-1:0] pullup_en_o,
    output reg [WIDTH-1:0] port_in_o
);
    always @(posedge clk_i) begin
        if (rst_i) begin
            pad_oe_o <= {WIDTH{1'b0}};
            pullup_en_o <= {WIDTH{1'b0}};
            port_in_o <= {WIDTH{1'b0}};
        end else begin
            pad_oe_o <= port_oe_i & ~disable_i;
            pullup_en_o <= port_pullup_i & ~disable_i;
            port_in_o <= pad_in_i & ~disable_i;
        end
    end
endmodule

`default_nettype wire

// File: arcc_regs.v
// converter result, compare and configuration registers with wishbone slave
`timescale 1ns/1ps
`default_nettype none

`include "arcc_map.vh"

// Behaviour
// - result low holds low eight bits of 10-bit result, whole 8-bit result
// - results load on each completion unless blocked, or compare enabled and not met
// - 10-bit mode, reading result high blocks transfers until result low read
// - completions while blocked are discarded
// - 8-bit mode, reading result high never blocks
// - changing resolution invalidates result low until next conversion
// - compare high holds upper two compare bits, used only in 10-bit mode
// - compare low compared with low eight result bits in both modes
// - config bit 7 picks high speed (0) or low power (1)
// - config bits 6:5 divide converter clock by 1, 2, 4, 8
// - config bit 4 picks short (0) or long (1) sample time
// - config bits 3:2 pick 8-bit (00) or 10-bit (10); others reserved
// - config bits 1:0 pick bus, bus/2, alternate, internal async clock
// - first pin-disable register bit n controls channel n, 0 to 7
// - second pin-disable register bit n controls channel n+8
// - pin-disable bit 0 keeps port control, 1 removes it
// - upper result bits read zero in 8-bit mode
// - disabled pin: output off, input reads zero, pullup off
module arcc_regs (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [31:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    input wire conv_done_i,
    input wire [9:0] conv_result_i,
    input wire conv_active_i,
    input wire compare_enable_i,
    input wire compare_greater_i,
    input wire alternate_clock_i,
    input wire internal_async_clock_i,
    output wire converter_clock_o,
    output reg low_power_o,
    output reg long_sample_o,
    output reg mode_10bit_o,
    output reg result_loaded_o,
    input wire [15:0] port_oe_i,
    input wire [15:0] port_pullup_i,
    input wire [15:0] pad_in_i,
    output wire [15:0] pad_oe_o,
    output wire [15:0] pullup_en_o,
    output wire [15:0] port_in_o
);
    reg [7:0] result_low_byte_q;
    reg [1:0] result_high_bits_q;
    reg [7:0] compare_value_high_q;
    reg [7:0] compare_value_low_q;
    reg [7:0] converter_configuration_q;
    reg [7:0] analog_pin_disable_0_7_q;
    reg [7:0] analog_pin_disable_8_15_q;
    reg lock_q;

    wire access = cyc_i & stb_i & ~ack_o;
    wire wr = access & we_i & sel_i[0];
    wire rd = access & ~we_i;
    wire [7:0] addr = adr_i[7:0];
    wire hit_rh = (addr == `ARCC_OFF_RESULT_HIGH);
    wire hit_rl = (addr == `ARCC_OFF_RESULT_LOW);
    wire [1:0] mode = converter_configuration_q[`ARCC_CFG_MODE_HI:`ARCC_CFG_MODE_LO];
    wire is_10bit = (mode == `ARCC_MODE_10BIT);
    wire [9:0] cmp_value = is_10bit ?
        {compare_value_high_q[1:0], compare_value_low_q} :
        {2'b00, compare_value_low_q};
    wire [9:0] cmp_result = is_10bit ? conv_result_i : {2'b00, conv_result_i[7:0]};
    wire cmp_ge = (cmp_result >= cmp_value);
    wire cmp_met = compare_greater_i ? cmp_ge : ~cmp_ge;
    wire load = conv_done_i & ~lock_q & (~compare_enable_i | cmp_met);
    wire cfg_wr = wr && (addr == `ARCC_OFF_CONFIG);
    wire mode_change = cfg_wr &&
        (dat_i[`ARCC_CFG_MODE_HI:`ARCC_CFG_MODE_LO] != mode);
    reg [7:0] rdata;

    // register writes and result capture
    always @(posedge clk_i) begin
        if (rst_i) begin
            compare_value_high_q <= `ARCC_RST_CMP;
            compare_value_low_q <= `ARCC_RST_CMP;
            converter_configuration_q <= `ARCC_RST_CONFIG;
            analog_pin_disable_0_7_q <= `ARCC_RST_PIN_DIS;
            analog_pin_disable_8_15_q <= `ARCC_RST_PIN_DIS;
            result_low_byte_q <= `ARCC_RST_RESULT;
            result_high_bits_q <= 2'b00;
            lock_q <= 1'b0;
            result_loaded_o <= 1'b0;
        end else begin
            if (wr) begin
                if (addr == `ARCC_OFF_CMP_HIGH) begin
                    compare_value_high_q <= {6'h00, dat_i[1:0]};
                end else if (addr == `ARCC_OFF_CMP_LOW) begin
                    compare_value_low_q <= dat_i[7:0];
                end else if (addr == `ARCC_OFF_CONFIG) begin
                    converter_configuration_q <= dat_i[7:0];
                end else if (addr == `ARCC_OFF_PIN_DIS_0_7) begin
                    analog_pin_disable_0_7_q <= dat_i[7:0];
                end else if (addr == `ARCC_OFF_PIN_DIS_8_15) begin
                    analog_pin_disable_8_15_q <= dat_i[7:0];
                end
            end
            result_loaded_o <= load;
            if (mode_change) begin
                // stale result dropped, interlock released
                result_low_byte_q <= `ARCC_RST_RESULT;
                result_high_bits_q <= 2'b00;
                lock_q <= 1'b0;
            end else begin
                if (load) begin
                    result_low_byte_q <= conv_result_i[7:0];
                    result_high_bits_q <= is_10bit ? conv_result_i[9:8] : 2'b00;
                end
                if (rd && hit_rl) begin
                    lock_q <= 1'b0;
                end else if (rd && hit_rh && is_10bit) begin
                    lock_q <= 1'b1;
                end
            end
        end
    end

    // read decode, unmapped reads return zero
    always @* begin
        if (hit_rh) begin
            rdata = {6'h00, is_10bit ? result_high_bits_q : 2'b00};
        end else if (hit_rl) begin
            rdata = result_low_byte_q;
        end else if (addr == `ARCC_OFF_CMP_HIGH) begin
            rdata = compare_value_high_q;
        end else if (addr == `ARCC_OFF_CMP_LOW) begin
            rdata = compare_value_low_q;
        end else if (addr == `ARCC_OFF_CONFIG) begin
            rdata = converter_configuration_q;
        end else if (addr == `ARCC_OFF_PIN_DIS_0_7) begin
            rdata = analog_pin_disable_0_7_q;
        end else if (addr == `ARCC_OFF_PIN_DIS_8_15) begin
            rdata = analog_pin_disable_8_15_q;
        end else begin
            rdata = 8'h00;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
            low_power_o <= 1'b0;
            long_sample_o <= 1'b0;
            mode_10bit_o <= 1'b0;
        end else begin
            ack_o <= access;
            dat_o <= rd ? {24'h00_0000, rdata} : 32'h0000_0000;
            low_power_o <= converter_configuration_q[`ARCC_CFG_LOW_POWER];
            long_sample_o <= converter_configuration_q[`ARCC_CFG_LONG_SAMPLE];
            mode_10bit_o <= is_10bit;
        end
    end

    arcc_clk_gen u_clk (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .src_sel_i(converter_configuration_q[`ARCC_CFG_SRC_HI:`ARCC_CFG_SRC_LO]),
        .div_sel_i(converter_configuration_q[`ARCC_CFG_DIV_HI:`ARCC_CFG_DIV_LO]),
        .alternate_clock_i(alternate_clock_i),
        .internal_async_clock_i(internal_async_clock_i),
        .hold_i(conv_active_i),
        .converter_clock_o(converter_clock_o)
    );

    arcc_pin_gate #(.WIDTH(8)) u_pins_lo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .disable_i(analog_pin_disable_0_7_q),
        .port_oe_i(port_oe_i[7:0]),
        .port_pullup_i(port_pullup_i[7:0]),
        .pad_in_i(pad_in_i[7:0]),
        .pad_oe_o(pad_oe_o[7:0]),
        .pullup_en_o(pullup_en_o[7:0]),
        .port_in_o(port_in_o[7:0])
    );

    arcc_pin_gate #(.WIDTH(8)) u_pins_hi (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .disable_i(analog_pin_disable_8_15_q),
        .port_oe_i(port_oe_i[15:8]),
        .port_pullup_i(port_pullup_i[15:8]),
        .pad_in_i(pad_in_i[15:8]),
        .pad_oe_o(pad_oe_o[15:8]),
        .pullup_en_o(pullup_en_o[15:8]),
        .port_in_o(port_in_o[15:8])
    );
endmodule

`default_nettype wire

// File: arcc_regs_chk.sv
// bus, result and pin checks on the register block
`timescale 1ns/1ps
`default_nettype none
module arcc_regs_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic [31:0] dat_o,
    input wire logic conv_done_i,
    input wire logic compare_enable_i,
    input wire logic mode_10bit_o,
    input wire logic result_loaded_o,
    input wire logic [15:0] port_oe_i,
    input wire logic [15:0] port_pullup_i,
    input wire logic [15:0] pad_in_i,
    input wire logic [15:0] pad_oe_o,
    input wire logic [15:0] pullup_en_o,
    input wire logic [15:0] port_in_o
);
default clocking cb @(posedge clk_i); endclocking
default disable iff (rst_i);
chk_ack_one_wait: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack late");
chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held");
chk_read_upper: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("upper data set");
chk_load_open: assert property (conv_done_i && !compare_enable_i && !mode_10bit_o
    |=> result_loaded_o)
    else $error("result not loaded");
chk_load_cause: assert property (result_loaded_o |-> $past(conv_done_i))
    else $error("load without completion");
chk_pad_oe: assert property ((pad_oe_o & ~$past(port_oe_i)) == 16'h0)
    else $error("pad driven unasked");
chk_pullup_gate: assert property ((pullup_en_o & ~$past(port_pullup_i)) == 16'h0)
    else $error("pullup unasked");
chk_port_in: assert property ((port_in_o & ~$past(pad_in_i)) == 16'h0)
    else $error("input not gated");
endmodule
bind arcc_regs arcc_regs_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .ack_o(ack_o), .dat_o(dat_o), .conv_done_i(conv_done_i),
    .compare_enable_i(compare_enable_i), .mode_10bit_o(mode_10bit_o),
    .result_loaded_o(result_loaded_o), .port_oe_i(port_oe_i),
    .port_pullup_i(port_pullup_i), .pad_in_i(pad_in_i), .pad_oe_o(pad_oe_o),
    .pullup_en_o(pullup_en_o), .port_in_o(port_in_o));
`default_nettype wire

// File: arcc_regs_bench.sv
// self-checking bench for the register block
`timescale 1ns/1ps
`default_nettype none
`include "arcc_map.vh"
module arcc_regs_bench;
logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, done = 0, cen = 0, cgt = 0;
logic [31:0] adr = 0, wdat = 0, dat_o;
logic [9:0] res = 0;
logic [15:0] poe = 0, ppu = 0, pin = 0, pad_oe, pu_en, p_in;
logic ack_o, ck, lp, ls, m10;
logic [7:0] q;
int fails = 0, n_compared = 0, cyc_cnt = 0, n;
always #10 clk_i = ~clk_i;
arcc_regs uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
    .conv_done_i(done), .conv_result_i(res), .conv_active_i(1'b0),
    .compare_enable_i(cen), .compare_greater_i(cgt), .alternate_clock_i(1'b0),
    .internal_async_clock_i(1'b0), .converter_clock_o(ck), .low_power_o(lp),
    .long_sample_o(ls), .mode_10bit_o(m10), .result_loaded_o(), .port_oe_i(poe),
    .port_pullup_i(ppu), .pad_in_i(pin), .pad_oe_o(pad_oe), .pullup_en_o(pu_en),
    .port_in_o(p_in));
task wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
endtask
task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
        $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        fails++;
    end
endtask
task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= {24'h0, a};
    wdat <= {24'h0, d};
    k = 0;
    do begin
        @(posedge clk_i);
        k++;
    end while (ack_o !== 1'b1 && k < 50);
    q = dat_o[7:0];
    cyc <= 0;
    stb <= 0;
    we <= 0;
    @(posedge clk_i);
    if (k >= 50) fails++;
endtask
task rd(input logic [7:0] a, input logic [7:0] e);
    wb(0, a, 8'h0);
    chk({8'h0, q}, {8'h0, e});
endtask
task conv(input logic [9:0] r);
    done <= 1;
    res <= r;
    @(posedge clk_i);
    done <= 0;
    @(posedge clk_i);
endtask
task ticks(input int e);
    repeat (20) @(posedge clk_i);
    n = 0;
    repeat (64) begin
        @(posedge clk_i);
        n += ck;
    end
    chk(n[15:0], e[15:0]);
endtask
always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
        fails++;
        wrap_up;
    end
end
initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    rd(`ARCC_OFF_CONFIG, 8'h00);
    wb(1, `ARCC_OFF_CMP_HIGH, 8'hff);
    rd(`ARCC_OFF_CMP_HIGH, 8'h03);
    wb(1, `ARCC_OFF_CMP_LOW, 8'ha5);
    rd(`ARCC_OFF_CMP_LOW, 8'ha5);
    wb(1, `ARCC_OFF_PIN_DIS_0_7, 8'h01);
    wb(1, `ARCC_OFF_PIN_DIS_8_15, 8'h80);
    rd(`ARCC_OFF_PIN_DIS_8_15, 8'h80);
    wb(1, `ARCC_OFF_RESULT_LOW, 8'h77);
    rd(`ARCC_OFF_RESULT_LOW, 8'h00);
    rd(8'h40, 8'h00);
    wb(1, `ARCC_OFF_CONFIG, 8'h98);
    chk({13'h0, lp, ls, m10}, 16'h0007);
    conv(10'h2c3);
    rd(`ARCC_OFF_RESULT_HIGH, 8'h02);
    conv(10'h1ff);
    rd(`ARCC_OFF_RESULT_LOW, 8'hc3);
    conv(10'h1ff);
    rd(`ARCC_OFF_RESULT_LOW, 8'hff);
    cen <= 1;
    cgt <= 1;
    conv(10'h100);
    rd(`ARCC_OFF_RESULT_LOW, 8'hff);
    conv(10'h3c0);
    rd(`ARCC_OFF_RESULT_HIGH, 8'h03);
    rd(`ARCC_OFF_RESULT_LOW, 8'hc0);
    cen <= 0;
    wb(1, `ARCC_OFF_CONFIG, 8'h00);
    rd(`ARCC_OFF_RESULT_LOW, 8'h00);
    conv(10'h3a5);
    rd(`ARCC_OFF_RESULT_HIGH, 8'h00);
    conv(10'h011);
    rd(`ARCC_OFF_RESULT_LOW, 8'h11);
    cen <= 1;
    cgt <= 0;
    conv(10'h3a0);
    rd(`ARCC_OFF_RESULT_LOW, 8'ha0);
    conv(10'h0b0);
    rd(`ARCC_OFF_RESULT_LOW, 8'ha0);
    cen <= 0;
    poe <= 16'hffff;
    ppu <= 16'hffff;
    pin <= 16'hffff;
    repeat (2) @(posedge clk_i);
    chk(pad_oe, 16'h7ffe);
    chk(p_in, 16'h7ffe);
    chk(pu_en, 16'h7ffe);
    wb(1, `ARCC_OFF_CONFIG, 8'h60);
    ticks(8);
    wb(1, `ARCC_OFF_CONFIG, 8'h01);
    ticks(32);
    wrap_up;
end
endmodule
`default_nettype wire
